/* File: src/wwdt_top.sv */
// Windowed watchdog timer with classic Wishbone register access.
// Assumes wd_counter_clock arrives as a slow pin level and that the CPU
// drives clear, key, debug and fuse signals on clk_sys_i.
`timescale 1ns/100ps
`default_nettype none
`include "wwdt_cfg.svh"

module wwdt_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic wd_counter_clock_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic io_register_key_i,
  input wire logic debug_halt_i,
  input wire logic [7:0] boot_config_fuse_i,
  output logic wd_reset_req_o,
  output logic wd_running_o
);

  // ========================================================================
  // Declarations
  logic wdclk_meta;                       // First synchroniser stage
  logic wdclk_sync;                       // Second synchroniser stage
  logic wdclk_last;                       // Previous synchronised level
  logic tick;                             // One watchdog clock edge
  logic booted;                           // Fuse load done
  logic [2:0] key_cnt;                    // Timed write window count
  logic key_open;                         // Protected write allowed
  logic bus_req;                          // Valid bus cycle
  logic [1:0] bus_idx;                    // Register index
  logic wr_ctrl;                          // Accepted control write
  logic wr_stat;                          // Accepted status write
  wwdt_pkg::wwdt_ctrl_type ctrl;          // Software view of control
  wwdt_pkg::wwdt_ctrl_type act;           // Control seen by the counter
  logic lock;                             // Configuration lock
  logic sync_pending_flag;                // Control transfer running
  logic [1:0] cfg_ticks;                  // Ticks seen by control transfer
  logic cfg_apply;                        // Control transfer finishes
  logic clr_pend;                         // Clear being synchronised
  logic [1:0] clr_ticks;                  // Ticks seen by clear transfer
  logic clr_apply;                        // Clear reaches counter
  wwdt_pkg::wwdt_state_type state;        // Sequencer state
  logic [13:0] cnt;                       // Watchdog counter
  logic [13:0] per_dur;                   // Open period length
  logic [13:0] win_dur;                   // Closed period length
  logic per_end;                          // Open period ends this tick
  logic win_end;                          // Closed period ends this tick
  logic fire;                             // Reset condition

  // ========================================================================
  // Duration decode
  // Codes 1..B give 8 to 8K cycles; reserved codes take the longest
  // A shift keeps the decode small; each code from 1 to B doubles the length
  function automatic logic [13:0] dur_f(input logic [3:0] code);
    logic [13:0] d;
    d = `WWDT_DUR_LONGEST;
    if (code >= `WWDT_CODE_MIN && code <= `WWDT_CODE_MAX) begin
      d = 14'h0001 << (code + `WWDT_DUR_SHIFT);
    end
    return d;
  endfunction

  assign per_dur = dur_f(act.period);
  assign win_dur = dur_f(act.window);
  // Compare at-or-above so that a period shortened while counting
  // still ends at the next tick instead of waiting for the counter to wrap
  assign per_end = tick && (cnt >= per_dur - 14'h0001);
  assign win_end = tick && (cnt >= win_dur - 14'h0001);

  // ========================================================================
  // Oscillator clock sampling
  // Two flops, then edge detection on the settled level
  // The oscillator is far slower than this clock, so no edge is missed
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wdclk_meta <= 1'b0;
      wdclk_sync <= 1'b0;
      wdclk_last <= 1'b0;
    end else begin
      wdclk_meta <= wd_counter_clock_i;
      wdclk_sync <= wdclk_meta;
      wdclk_last <= wdclk_sync;
    end
  end

  // Rising edge of the oscillator clock; runs in every sleep state
  assign tick = wdclk_sync && !wdclk_last;

  // ========================================================================
  // Timed write protection window
  // The key opens a short window; any other write leaves bits untouched
  // System clocks stand in for instructions: four edges after the key
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      key_cnt <= 3'h0;
    end else if (io_register_key_i) begin
      key_cnt <= `WWDT_KEY_WINDOW;
    end else if (key_cnt != 3'h0) begin
      key_cnt <= key_cnt - 3'h1;
    end
  end

  assign key_open = (key_cnt != 3'h0);

  // ========================================================================
  // Wishbone slave
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_idx = wb_adr_i[3:2];
  // Writes take effect on the edge where the master samples ack
  assign wr_ctrl = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0] &&
                   (bus_idx == `WWDT_CTRL_IDX);
  assign wr_stat = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0] &&
                   (bus_idx == `WWDT_STAT_IDX);

  // Acknowledge one cycle after the request, drop the cycle after
  // No further wait states; every access, refused or not, is acknowledged
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
    end
  end

  // Read data, unmapped indices read zero
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_ack_o) begin
      case (bus_idx)
        `WWDT_CTRL_IDX: begin
          wb_dat_o <= {24'h00_0000, ctrl};
        end
        `WWDT_STAT_IDX: begin
          wb_dat_o <= {24'h00_0000, lock, 6'h00, sync_pending_flag};
        end
        default: begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ========================================================================
  // Control register and boot load
  // Fuse byte is caught on the first clock after reset release
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      booted <= 1'b0;
      ctrl <= `WWDT_CTRL_RST;
    end else if (!booted) begin
      booted <= 1'b1;
      ctrl <= boot_config_fuse_i;
    end else if (wr_ctrl && key_open && !lock && !sync_pending_flag) begin
      // Locked or unkeyed writes are dropped; writes while busy too
      ctrl <= wb_dat_i[7:0];
    end
  end

  // Lock bit: set by fuse enable or software, cleared only in debug
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lock <= 1'b0;
    end else if (!booted) begin
      lock <= (boot_config_fuse_i[`WWDT_PER_MSB:`WWDT_PER_LSB] != `WWDT_CODE_OFF);
    end else if (wr_stat && key_open) begin
      if (wb_dat_i[`WWDT_LOCK_BIT]) begin
        lock <= 1'b1;
      end else if (debug_halt_i) begin
        lock <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Control transfer into the counter
  // Busy from the write until the second oscillator edge
  // Writes arriving while busy are dropped, so software must poll the flag
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync_pending_flag <= 1'b0;
      cfg_ticks <= 2'h0;
    end else if (!booted || (wr_ctrl && key_open && !lock && !sync_pending_flag)) begin
      sync_pending_flag <= 1'b1;
      cfg_ticks <= 2'h0;
    end else if (cfg_apply) begin
      sync_pending_flag <= 1'b0;
      cfg_ticks <= 2'h0;
    end else if (sync_pending_flag && tick) begin
      cfg_ticks <= cfg_ticks + 2'h1;
    end
  end

  assign cfg_apply = sync_pending_flag && tick &&
                     (cfg_ticks == `WWDT_SYNC_TICKS - 2'h1);

  // Counter-side copy of the control fields
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      act <= `WWDT_CTRL_RST;
    end else if (cfg_apply) begin
      act <= ctrl;
    end
  end

  // ========================================================================
  // Clear instruction transfer
  // Clears arriving while one is pending are dropped
  // A clear in the very cycle that the pending one lands is dropped too
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      clr_pend <= 1'b0;
      clr_ticks <= 2'h0;
    end else if (clr_apply) begin
      clr_pend <= 1'b0;
      clr_ticks <= 2'h0;
    end else if (!clr_pend && watchdog_clear_instr_i) begin
      clr_pend <= 1'b1;
      clr_ticks <= 2'h0;
    end else if (clr_pend && tick) begin
      clr_ticks <= clr_ticks + 2'h1;
    end
  end

  assign clr_apply = clr_pend && tick &&
                     (clr_ticks == `WWDT_SYNC_TICKS - 2'h1);

  // ========================================================================
  // Sequencer and counter
  // Reset condition: missed open period or clear in closed period
  // A halted CPU never triggers a request; pending clears still land
  assign fire = !debug_halt_i &&
                ((((state == wwdt_pkg::WWDT_OPEN) || (state == wwdt_pkg::WWDT_ARM)) &&
                  per_end && !clr_apply) ||
                 ((state == wwdt_pkg::WWDT_CLOSED) && clr_apply));

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= wwdt_pkg::WWDT_OFF;
      cnt <= 14'h0000;
    end else if (act.period == `WWDT_CODE_OFF) begin
      // Zero period keeps the watchdog stopped
      state <= wwdt_pkg::WWDT_OFF;
      cnt <= 14'h0000;
    end else if (debug_halt_i) begin
      // Halted CPU: counter held at zero, window restarts armed
      cnt <= 14'h0000;
      if (act.window != `WWDT_CODE_OFF) begin
        state <= wwdt_pkg::WWDT_ARM;
      end else begin
        state <= wwdt_pkg::WWDT_OPEN;
      end
    end else begin
      case (state)
        wwdt_pkg::WWDT_OFF: begin
          // Start on a non-zero period
          cnt <= 14'h0000;
          if (act.window != `WWDT_CODE_OFF) begin
            state <= wwdt_pkg::WWDT_ARM;
          end else begin
            state <= wwdt_pkg::WWDT_OPEN;
          end
        end
        wwdt_pkg::WWDT_ARM: begin
          // One normal timeout until the first clear opens the window
          if (act.window == `WWDT_CODE_OFF) begin
            state <= wwdt_pkg::WWDT_OPEN;
          end else if (clr_apply) begin
            state <= wwdt_pkg::WWDT_CLOSED;
            cnt <= 14'h0000;
          end else if (per_end) begin
            cnt <= 14'h0000;
          end else if (tick) begin
            cnt <= cnt + 14'h0001;
          end
        end
        wwdt_pkg::WWDT_CLOSED: begin
          // Clears are illegal here; length from the window field
          if (act.window == `WWDT_CODE_OFF) begin
            state <= wwdt_pkg::WWDT_OPEN;
            cnt <= 14'h0000;
          end else if (clr_apply) begin
            state <= wwdt_pkg::WWDT_CLOSED;
            cnt <= 14'h0000;
          end else if (win_end) begin
            state <= wwdt_pkg::WWDT_OPEN;
            cnt <= 14'h0000;
          end else if (tick) begin
            cnt <= cnt + 14'h0001;
          end
        end
        wwdt_pkg::WWDT_OPEN: begin
          // Normal timeout, or open period of window mode
          if (clr_apply) begin
            cnt <= 14'h0000;
            if (act.window != `WWDT_CODE_OFF) begin
              state <= wwdt_pkg::WWDT_CLOSED;
            end
          end else if (cfg_apply && act.window == `WWDT_CODE_OFF &&
                       ctrl.window != `WWDT_CODE_OFF) begin
            // Window newly enabled: wait for the first clear
            state <= wwdt_pkg::WWDT_ARM;
            cnt <= 14'h0000;
          end else if (per_end) begin
            cnt <= 14'h0000;
            if (act.window != `WWDT_CODE_OFF) begin
              state <= wwdt_pkg::WWDT_CLOSED;
            end
          end else if (tick) begin
            cnt <= cnt + 14'h0001;
          end
        end
        default: begin
          state <= wwdt_pkg::WWDT_OFF;
          cnt <= 14'h0000;
        end
      endcase
    end
  end

  // ========================================================================
  // Outputs
  // Reset request is a single system-clock pulse per condition
  // Running drops while halted so the host can see the pause
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wd_reset_req_o <= 1'b0;
      wd_running_o <= 1'b0;
    end else begin
      wd_reset_req_o <= fire;
      wd_running_o <= (state != wwdt_pkg::WWDT_OFF) && !debug_halt_i;
    end
  end

endmodule

`default_nettype wire

/* File: common/wwdt_cfg.svh */
// Constants of the windowed watchdog: offsets, field positions, resets, counts.
// Assumes inclusion by bare name from the package and the design module.
//
// Overview of operation
// - Non-zero period field starts watchdog; zero stops
// - Zero window field normal mode, else window
// - Codes 1..B select 8 to 8K cycles
// - Counter runs from the 1 kHz oscillator clock
// - Normal mode: missed clear raises reset request
// - Accepted clear restarts period from zero
// - Clear during closed period raises reset request
// - Open period follows closed; missed clear resets
// - Window newly enabled waits for first clear
// - Counting halts while CPU is debug halted
// - Counter cleared while CPU is debug halted
// - After debug halt, one normal timeout first
// - Clear lands on the second tick; extra clears ignored
// - Control writes synchronized, busy flag meanwhile
// - Lock set makes control register read-only
// - Lock written only to one; cleared in debug
// - Control reset from fuse; enabled fuse locks
// - Key then write within four instructions
// - Keeps counting in sleep while oscillator runs
// - Lock at status bit 7, busy bit 0
`ifndef WWDT_CFG_SVH
`define WWDT_CFG_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define WWDT_CTRL_IDX 2'h0
`define WWDT_STAT_IDX 2'h1

// ==========================================================================
// Field positions
`define WWDT_PER_LSB 0
`define WWDT_PER_MSB 3
`define WWDT_WIN_LSB 4
`define WWDT_WIN_MSB 7
`define WWDT_LOCK_BIT 7
`define WWDT_BUSY_BIT 0

// ==========================================================================
// Reset values and duration codes
`define WWDT_CTRL_RST 8'h00
`define WWDT_CODE_OFF 4'h0
`define WWDT_CODE_MIN 4'h1
`define WWDT_CODE_MAX 4'hB

// ==========================================================================
// Timing counts
`define WWDT_DUR_SHIFT 4'h2
`define WWDT_DUR_LONGEST 14'h2000
`define WWDT_SYNC_TICKS 2'h2
`define WWDT_KEY_WINDOW 3'h4

`endif

/* File: common/wwdt_pkg.sv */
// Types shared by the windowed watchdog design.
// Assumes the constants header sits in the include path.
`include "wwdt_cfg.svh"

package wwdt_pkg;

  // Watchdog sequencer states, Gray coded along off-arm-closed-open
  typedef enum logic [1:0] {
    WWDT_OFF    = 2'h0,
    WWDT_ARM    = 2'h1,
    WWDT_CLOSED = 2'h3,
    WWDT_OPEN   = 2'h2
  } wwdt_state_type;

  // Control register layout
  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } wwdt_ctrl_type;

endpackage

/* File: test/wwdt_top_chk.sv */
// Port checks for the windowed watchdog top.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module wwdt_top_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic debug_halt_i,
  input wire logic wd_reset_req_o,
  input wire logic wd_running_o
);
  // ==========================================
  // Common clock and reset
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================
  // Bus answers
  a_ack_answer:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_cause:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack wider than one cycle");
  a_dat_upper:
    assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_stat_rsvd:
    assert property (wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h1 |-> wb_dat_o[6:1] == 6'h00)
    else $error("status reserved bits set");
  // ==========================================
  // Reset request and debug halt
  a_req_pulse:
    assert property (wd_reset_req_o |=> !wd_reset_req_o)
    else $error("reset request wider than one cycle");
  a_halt_stop:
    assert property (debug_halt_i |=> !wd_running_o)
    else $error("running while halted");
  a_halt_quiet:
    assert property (debug_halt_i [*4] |-> !wd_reset_req_o)
    else $error("reset request while halted");
  a_boot_quiet:
    assert property ($fell(rst_i) |-> !wb_ack_o && !wd_reset_req_o && !wd_running_o)
    else $error("outputs active after reset");
  // Main scenarios reached
  c_write: cover property (wb_ack_o && wb_we_i);
  c_req: cover property (wd_reset_req_o);
  c_halt: cover property (debug_halt_i && $past(wd_running_o));
endmodule

bind wwdt_top wwdt_top_chk chk_u (
  .clk_sys_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .debug_halt_i, .wd_reset_req_o, .wd_running_o
);
`default_nettype wire

/* File: test/wwdt_cpu_model.sv */
// CPU-side partner: Wishbone master plus clear and key strobes.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module wwdt_cpu_model (
  input wire logic clk_sys_i,
  input wire logic ack_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o,
  output logic we_o,
  output logic [3:0] adr_o,
  output logic [31:0] dat_o,
  output logic clr_o,
  output logic key_o
);
  // ==========================================
  // Idle levels at time zero
  initial begin
    cyc_o = 1'b0;
    we_o = 1'b0;
    adr_o = 4'h0;
    dat_o = 32'h00000000;
    clr_o = 1'b0;
    key_o = 1'b0;
  end
  // One clear strobe, one cycle wide
  task automatic clr();
    clr_o <= 1'b1;
    @(posedge clk_sys_i);
    clr_o <= 1'b0;
  endtask
  // One classic cycle, key strobe first if asked; gives up after 20 cycles
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
    input logic k, output logic [7:0] q, output logic ok);
    int n;
    n = 0;
    if (k) begin
      key_o <= 1'b1;
      @(posedge clk_sys_i);
      key_o <= 1'b0;
    end
    cyc_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= {24'($urandom), d};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (ack_i !== 1'b1 && n < 20);
    q = rdat_i[7:0];
    ok = ack_i;
    cyc_o <= 1'b0;
    @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

/* File: test/wwdt_top_tb.sv */
// Self-checking bench for the windowed watchdog top.
// Assumes the CPU partner model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module wwdt_top_tb;
  logic clk, rst, osc, dbg, cyc, we, clr, key, ack, req, run;
  logic [3:0] adr;
  logic [7:0] fuse;
  logic [31:0] wdat, rdat;
  int bad_count, num_checks, pulses, n, p, m_ctrl, m_lock;
  // ==========================================
  // System clock 50 ns; oscillator 400 ns at an unrelated phase
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    #37.3;
    forever #200 osc = ~osc;
  end
  wwdt_top dut_u (
    .clk_sys_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wd_counter_clock_i(osc), .watchdog_clear_instr_i(clr), .io_register_key_i(key),
    .debug_halt_i(dbg), .boot_config_fuse_i(fuse), .wd_reset_req_o(req), .wd_running_o(run)
  );
  wwdt_cpu_model cpu_u (
    .clk_sys_i(clk), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .we_o(we),
    .adr_o(adr), .dat_o(wdat), .clr_o(clr), .key_o(key)
  );
  // Counts reset requests
  always @(posedge clk) begin
    if (req === 1'b1) begin
      pulses <= pulses + 1;
    end
  end
  // ==========================================
  // Checking and bus helpers
  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic ok);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: mismatch", $time);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic ok;
    cpu_u.bus(1'b0, a, 8'h00, 1'b0, q, ok);
    chk(ok && q === e);
    if (ok !== 1'b1) print_verdict();
  endtask
  // Polls status until the transfer to the counter clock is over
  task automatic idle();
    logic [7:0] q;
    logic ok;
    for (int i = 0; i < 30; i++) begin
      cpu_u.bus(1'b0, 4'h4, 8'h00, 1'b0, q, ok);
      if (ok !== 1'b1) break;
      if (q[0] === 1'b0) return;
    end
    chk(1'b0);
    print_verdict();
  endtask
  // Write, then the model decides what the registers now hold
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic k);
    logic [7:0] q;
    logic ok;
    idle();
    cpu_u.bus(1'b1, a, d, k, q, ok);
    chk(ok);
    if (ok !== 1'b1) print_verdict();
    if (k && a == 4'h0 && m_lock == 0) m_ctrl = d;
    if (k && a == 4'h4 && d[7]) m_lock = 1;
    if (k && a == 4'h4 && !d[7] && dbg) m_lock = 0;
  endtask
  // Cycles until the next reset request, bounded
  task automatic gap(input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge clk);
      if (req === 1'b1) return;
    end
    chk(1'b0);
    print_verdict();
  endtask
  // ==========================================
  // Main sequence
  initial begin
    rst = 1'b1;
    dbg = 1'b0;
    fuse = 8'h00;
    void'($urandom(7));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Zero fuse: unlocked, stopped, unmapped reads zero
    rd(4'h4, 8'h01);
    rd(4'h0, 8'h00);
    rd(4'h8, 8'h00);
    idle();
    chk(run === 1'b0);
    wr(4'h0, 8'h05, 1'b0);
    rd(4'h0, m_ctrl[7:0]);
    // Each period code doubles the timeout
    for (int c = 1; c < 5; c++) begin
      wr(4'h0, 8'(c), 1'b1);
      rd(4'h4, 8'h01);
      idle();
      rd(4'h0, m_ctrl[7:0]);
      gap(700);
      gap(700);
      chk(n > (32 << c) - 10 && n < (32 << c) + 10);
    end
    // Random clear spacing keeps a 16-tick period alive
    wr(4'h0, 8'h02, 1'b1);
    idle();
    // A period shortened mid-count may still end once before the clears
    repeat (24) @(posedge clk);
    p = pulses;
    repeat (12) begin
      repeat (8 + $urandom % 32) @(posedge clk);
      cpu_u.clr();
    end
    chk(pulses == p);
    wr(4'h0, 8'h00, 1'b1);
    idle();
    chk(run === 1'b0);
    // Window: closed 16 ticks from first clear, open 8
    wr(4'h0, 8'h21, 1'b1);
    idle();
    p = pulses;
    cpu_u.clr();
    repeat (160) @(posedge clk);
    cpu_u.clr();
    repeat (160) @(posedge clk);
    cpu_u.clr();
    repeat (40) @(posedge clk);
    chk(pulses == p);
    cpu_u.clr();
    gap(80);
    // Halt stops and clears; release runs one plain period
    dbg <= 1'b1;
    repeat (2) @(posedge clk);
    p = pulses;
    repeat (398) @(posedge clk);
    chk(pulses == p && run === 1'b0);
    dbg <= 1'b0;
    gap(100);
    chk(n > 50 && n < 70);
    // Lock freezes control; only debug clears it
    wr(4'h4, 8'h80, 1'b1);
    rd(4'h4, {m_lock[0], 7'h00});
    wr(4'h0, 8'h00, 1'b1);
    rd(4'h0, m_ctrl[7:0]);
    chk(run === 1'b1);
    wr(4'h4, 8'h00, 1'b1);
    rd(4'h4, {m_lock[0], 7'h00});
    dbg <= 1'b1;
    wr(4'h4, 8'h00, 1'b1);
    rd(4'h4, {m_lock[0], 7'h00});
    dbg <= 1'b0;
    // Enabled fuse boots locked with that setting
    rst <= 1'b1;
    fuse <= 8'h13;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(4'h4, 8'h81);
    rd(4'h0, 8'h13);
    idle();
    chk(run === 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
